// file: bench/cacc_pin_model.sv
// External source or load on one channel pin
`timescale 1ns/10ps
module cacc_pin_model (
  // Clock
  input wire logic clk,
  // Block side of the pin
  input wire logic drv_en,
  input wire logic drv_level,
  // Level the source is told to drive
  input wire logic want_level,
  // Resolved pin level
  output logic     pin_level
);
  logic lvl_q = 1'b0;
  int   held_q = 2;

  // A new level is taken only after the old one stood two cycles
  always @(posedge clk) begin
    if (want_level != lvl_q && held_q >= 2) begin
      lvl_q  <= want_level;
      held_q <= 1;
    end else if (held_q < 2) begin
      held_q <= held_q + 1;
    end
  end
  assign pin_level = drv_en ? drv_level : lvl_q;
endmodule : cacc_pin_model

// file: bench/cacc_properties.sv
// Port-level assertions for the capture/compare block
`timescale 1ns/10ps
module cacc_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Counter and pins
  input wire logic [15:0] cnt_value,
  input wire logic        cnt_tick,
  input wire logic [2:0]  channel_pin_i,
  input wire logic [2:0]  channel_pin_o,
  input wire logic [2:0]  channel_pin_oe,
  // Flags and interrupt lines
  input wire logic [2:0]  channel_event_flag,
  input wire logic [2:0]  channel_irq,
  input wire logic        partial_overflow_flag,
  input wire logic        partial_overflow_irq
);
  cacc_pkg::cacc_mode_reg_t m0_q;
  cacc_pkg::cacc_mode_reg_t m1_q;
  logic                     view_q;
  logic                     pwm_off;
  logic                     tog_off;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Shadows of channel 0 and 1 modes, comparator enable included
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m0_q   <= '0;
      m1_q   <= '0;
      view_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == cacc_pkg::ADDR_MODE0) m0_q <= reg_wdata;
      if (reg_addr == cacc_pkg::ADDR_PCFG) view_q <= reg_wdata[7];
      if (reg_addr == 8'h04 && !view_q) m0_q.comparator_enable <= 1'b0;
      if (reg_addr == 8'h05 && !view_q) m0_q.comparator_enable <= 1'b1;
      if (reg_addr == cacc_pkg::ADDR_MODE0 + 8'h01) m1_q <= reg_wdata;
      if (reg_addr == 8'h06 && !view_q) m1_q.comparator_enable <= 1'b0;
      if (reg_addr == 8'h07 && !view_q) m1_q.comparator_enable <= 1'b1;
    end
  end

  assign pwm_off = m0_q.pulse_enable && !m0_q.comparator_enable
                   && (m0_q.wide_pulse_select || !m0_q.toggle_enable);
  assign tog_off = m1_q.toggle_enable && !(m1_q.pulse_enable && m1_q.wide_pulse_select)
                   && !m1_q.comparator_enable;

  a_irq_follows_flag:
    assert property (channel_irq[0] == $past(channel_event_flag[0] && m0_q.channel_irq_enable))
    else $error("Irq out of step");
  a_flag_sticky:
    assert property ($fell(channel_event_flag[0])
      |-> $past(reg_wr && reg_addr == cacc_pkg::ADDR_FLAGS && !reg_wdata[0]))
    else $error("Flag fell alone");
  a_pin_rise_tick:
    assert property ((channel_pin_o & ~$past(channel_pin_o)) != 3'h0 |-> $past(cnt_tick))
    else $error("Pin rose without tick");
  a_ovf_cause:
    assert property ($rose(partial_overflow_flag) |-> $past(cnt_tick && cnt_value[7:0] == 8'h00))
    else $error("Overflow flag without overflow");
  a_ovf_irq_flag:
    assert property (partial_overflow_irq |-> $past(partial_overflow_flag))
    else $error("Overflow irq without flag");
  a_pwm_off_low:
    assert property ($past(pwm_off) && pwm_off |-> !channel_pin_o[0])
    else $error("Disabled pulse output not low");
  a_tog_off_hold:
    assert property ($past(tog_off) && $past(tog_off, 2) |-> $stable(channel_pin_o[1]))
    else $error("Disabled toggle moved");
  a_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("Read data outside slot");

  c_hso_rise: cover property ($rose(channel_pin_o[1]));
  c_overflow: cover property ($rose(partial_overflow_flag));
  c_irq: cover property ($rose(channel_irq[0]));
endmodule : cacc_properties

// file: bench/test_cacc_top.sv
// Self-checking bench for the capture/compare block
`timescale 1ns/10ps
module test_cacc_top;
  logic        clk;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [15:0] cnt_value;
  logic        cnt_tick;
  logic [2:0]  pin_lvl;
  logic [2:0]  pin_drv;
  logic [2:0]  pin_en;
  logic [2:0]  want;
  logic [2:0]  flag;
  logic [2:0]  irq;
  logic        ovf;
  logic        ovf_irq;
  logic [15:0] last;
  int          n_fail;
  int          n_checks;

  cacc_top dut_u (
    .clk                   (clk),
    .resetn                (resetn),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_rdata             (reg_rdata),
    .cnt_value             (cnt_value),
    .cnt_tick              (cnt_tick),
    .channel_pin_i         (pin_lvl),
    .channel_pin_o         (pin_drv),
    .channel_pin_oe        (pin_en),
    .channel_event_flag    (flag),
    .channel_irq           (irq),
    .partial_overflow_flag (ovf),
    .partial_overflow_irq  (ovf_irq)
  );

  cacc_pin_model pin_u [2:0] (
    .clk        (clk),
    .drv_en     (pin_en),
    .drv_level  (pin_drv),
    .want_level (want),
    .pin_level  (pin_lvl)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(16'(reg_rdata), 16'(exp));
    @(posedge clk);
  endtask : rd

  task automatic tick(input logic [15:0] v);
    cnt_value <= v;
    cnt_tick  <= 1'b1;
    @(posedge clk);
    cnt_tick <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : tick

  task automatic cap(input logic lvl, input logic hit, input logic [15:0] v);
    cnt_value <= v;
    want[0]   <= lvl;
    repeat (8) @(posedge clk);
    if (hit) last = v;
    rd(8'h04, last[7:0]);
    rd(8'h05, last[15:8]);
    chk(16'({flag[0], irq[0]}), {14'h0, hit, hit});
    chk(16'(pin_en), 16'h0000);
    rd(cacc_pkg::ADDR_PINS, {7'h00, lvl});
    wr(cacc_pkg::ADDR_FLAGS, 8'h00);
    chk(16'(flag[0]), 16'h0000);
  endtask : cap

  task automatic t_capture();
    logic [7:0] modes [3];
    modes = '{8'h21, 8'h11, 8'h31};
    for (int k = 0; k < 3; k++) begin
      wr(cacc_pkg::ADDR_MODE0, modes[k]);
      cap(1'b1, k != 1, 16'h1200 + 16'(k));
      cap(1'b0, k != 0, 16'hA500 + 16'(k));
    end
  endtask : t_capture

  task automatic t_timer();
    wr(cacc_pkg::ADDR_MODE0, 8'h49);
    wr(8'h04, 8'h34);
    rd(cacc_pkg::ADDR_MODE0, 8'h09);
    wr(8'h05, 8'h12);
    rd(cacc_pkg::ADDR_MODE0, 8'h49);
    tick(16'h1233);
    chk(16'(flag[0]), 16'h0000);
    tick(16'h1234);
    chk(16'({flag[0], irq[0]}), 16'h0003);
    reg_addr  <= cacc_pkg::ADDR_FLAGS;
    reg_wdata <= 8'h00;
    reg_wr    <= 1'b1;
    cnt_tick  <= 1'b1;
    @(posedge clk);
    reg_wr   <= 1'b0;
    cnt_tick <= 1'b0;
    repeat (2) @(posedge clk);
    chk(16'(flag[0]), 16'h0001);
  endtask : t_timer

  task automatic t_hso();
    wr(8'h01, 8'h4C);
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h01);
    for (int k = 0; k < 4; k++) begin
      if (k == 3) begin
        wr(8'h06, 8'h00);
        wr(cacc_pkg::ADDR_FLAGS, 8'h00);
      end
      tick(16'h0100);
      chk(16'({pin_lvl[1], flag[1]}), {14'h0, k != 1, k != 3});
    end
    chk(16'(pin_en), 16'h0002);
  endtask : t_hso

  task automatic t_freq();
    wr(8'h02, 8'h4E);
    wr(8'h08, 8'h10);
    wr(8'h09, 8'h20);
    tick(16'h5510);
    chk(16'({pin_lvl[2], flag[2]}), 16'h0002);
    rd(8'h08, 8'h30);
    wr(8'h09, 8'h00);
    tick(16'h0030);
    chk(16'({pin_lvl[2], flag[2]}), 16'h0001);
    rd(8'h08, 8'h30);
  endtask : t_freq

  task automatic t_pwm16();
    wr(8'h02, 8'h82);
    wr(8'h08, 8'h00);
    wr(8'h09, 8'h90);
    tick(16'h9000);
    chk(16'(pin_lvl[2]), 16'h0001);
    tick(16'h0100);
    chk(16'(pin_lvl[2]), 16'h0001);
    tick(16'h0000);
    chk(16'(pin_lvl[2]), 16'h0000);
  endtask : t_pwm16

  task automatic t_pwm();
    wr(cacc_pkg::ADDR_FLAGS, 8'h00);
    wr(cacc_pkg::ADDR_PCFG, 8'h20);
    wr(cacc_pkg::ADDR_MODE0, 8'h4A);
    wr(8'h04, 8'h80);
    wr(8'h05, 8'h40);
    tick(16'h0380);
    chk(16'({pin_lvl[0], flag[0]}), 16'h0003);
    tick(16'h0400);
    chk(16'({pin_lvl[0], ovf, ovf_irq}), 16'h0003);
    rd(8'h04, 8'h40);
    tick(16'h0440);
    chk(16'(pin_lvl[0]), 16'h0001);
    wr(8'h04, 8'h40);
    @(posedge clk);
    chk(16'(pin_lvl[0]), 16'h0000);
    wr(cacc_pkg::ADDR_PCFG, 8'h81);
    wr(8'h04, 8'h23);
    wr(8'h05, 8'h01);
    wr(cacc_pkg::ADDR_PCFG, 8'h01);
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h01);
    wr(cacc_pkg::ADDR_FLAGS, 8'h00);
    tick(16'h0300);
    chk(16'({pin_lvl[0], ovf}), 16'h0002);
    tick(16'h0400);
    chk(16'({pin_lvl[0], ovf}), 16'h0001);
    rd(8'h04, 8'h23);
    rd(8'h05, 8'h01);
  endtask : t_pwm

  task automatic final_report();
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  initial begin
    resetn    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    cnt_value = 16'h0000;
    cnt_tick  = 1'b0;
    want      = 3'h0;
    last      = 16'h0000;
    n_fail    = 0;
    n_checks  = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_capture();
    t_timer();
    t_hso();
    t_freq();
    t_pwm16();
    t_pwm();
    final_report();
  end

  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    final_report();
  end
endmodule : test_cacc_top

bind cacc_top cacc_properties chk_u (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cnt_value(cnt_value),
  .cnt_tick(cnt_tick), .channel_pin_i(channel_pin_i), .channel_pin_o(channel_pin_o),
  .channel_pin_oe(channel_pin_oe), .channel_event_flag(channel_event_flag),
  .channel_irq(channel_irq), .partial_overflow_flag(partial_overflow_flag),
  .partial_overflow_irq(partial_overflow_irq)
);

// file: hw/cacc_pkg.sv
// Constants, field layouts and types for the capture/compare channel block
package cacc_pkg;

  // Channel count
  localparam int NCH = 3;

  // Register offsets on the byte register port
  localparam logic [7:0] ADDR_MODE0 = 8'h00;  // channel_mode_reg n at ADDR_MODE0 + n
  localparam logic [7:0] ADDR_CPL0  = 8'h04;  // compare_low_byte n at ADDR_CPL0 + 2n
  localparam logic [7:0] ADDR_PCFG  = 8'h0C;  // pulse_config_reg
  localparam logic [7:0] ADDR_FLAGS = 8'h0D;  // event flags, write 0 to clear
  localparam logic [7:0] ADDR_PINS  = 8'h0E;  // synchronised channel pin levels

  // Field positions
  localparam int PCFG_VIEW_BIT = 7;
  localparam int PCFG_OVIE_BIT = 5;
  localparam int PCFG_CLS_LSB  = 0;
  localparam int FLAGS_OVF_BIT = 3;

  // Reset values
  localparam logic [7:0]  MODE_RST = 8'h00;
  localparam logic [15:0] CMP_RST  = 16'h0000;
  localparam logic [1:0]  CLS_RST  = 2'h0;

  // Cycle length select codes
  localparam logic [1:0] CLS_8  = 2'h0;
  localparam logic [1:0] CLS_9  = 2'h1;
  localparam logic [1:0] CLS_10 = 2'h2;
  localparam logic [1:0] CLS_11 = 2'h3;

  // Counter masks for each cycle length
  localparam logic [15:0] MASK_8  = 16'h00FF;
  localparam logic [15:0] MASK_9  = 16'h01FF;
  localparam logic [15:0] MASK_10 = 16'h03FF;
  localparam logic [15:0] MASK_11 = 16'h07FF;

  // Layout of channel_mode_reg, bit 7 down to bit 0
  typedef struct packed {
    logic wide_pulse_select;
    logic comparator_enable;
    logic rise_capture_enable;
    logic fall_capture_enable;
    logic match_flag_enable;
    logic toggle_enable;
    logic pulse_enable;
    logic channel_irq_enable;
  } cacc_mode_reg_t;

  // Operating mode of one channel
  typedef enum logic [2:0] {
    CM_IDLE,
    CM_CAPTURE,
    CM_TIMER,
    CM_HSO,
    CM_FREQ,
    CM_PWM_N,
    CM_PWM_16
  } cacc_chmode_t;

endpackage : cacc_pkg

// file: hw/cacc_top.sv
// Capture/compare channels of a programmable counter array
//
// Notes on behaviour
// - Capture mode copies the 16-bit counter into the channel compare register.
// - Rise/fall capture bits select rising, falling or any edge.
// - Every capture sets the event flag; interrupt requested when enabled.
// - Event flag survives interrupt service; only a software write clears it.
// - With both capture bits set, the pin level stays readable to software.
// - Timer mode compares counter with compare register and sets the flag.
// - With view bit clear, low byte write clears comparator enable; high byte write sets it.
// - High-speed output inverts the pin on each match; with match flag enable it also sets the flag.
// - Comparator disabled in high-speed output holds the pin level.
// - Frequency mode toggles on low-byte match and adds high byte to low.
// - Frequency mode with match flag enable flags full 16-bit equality.
// - 8-11 bit PWM with wide bit clear; cycle length codes 0 to 3 select 8 to 11 bits.
// - All 8-11 bit PWM channels share one cycle length.
// - 16-bit PWM when wide bit and pulse enable set; ignores cycle length.
// - Comparator disabled: toggles hold, every PWM mode drives low.
// - View bit routes compare addresses to compare or auto-reload register.
// - Config bit 5 enables interrupt on partial overflow at bit 8 to 11.
// - Match flag enable, comparator enabled, makes each 16-bit match (N-bit in 8-11 bit PWM) set the event flag outside capture mode.
// - Mode bit 0 enables the channel interrupt in every mode.
// - 8-bit PWM: high on low-byte match, low and reload on overflow.
// - 9-11 bit PWM: high on N-bit match, low, flag and reload on overflow.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module cacc_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Shared counter
  input  wire logic [15:0] cnt_value,
  input  wire logic        cnt_tick,
  // Channel pins
  input  wire logic [2:0]  channel_pin_i,
  output logic      [2:0]  channel_pin_o,
  output logic      [2:0]  channel_pin_oe,
  // Event and interrupt lines
  output logic      [2:0]  channel_event_flag,
  output logic      [2:0]  channel_irq,
  output logic             partial_overflow_flag,
  output logic             partial_overflow_irq
);

  localparam int NCH = cacc_pkg::NCH;

  // Mode decode from the mode register fields
  function automatic cacc_pkg::cacc_chmode_t chmode(input cacc_pkg::cacc_mode_reg_t m);
    cacc_pkg::cacc_chmode_t r;
    r = cacc_pkg::CM_IDLE;
    if (m.pulse_enable) begin
      if (m.wide_pulse_select) begin
        r = cacc_pkg::CM_PWM_16;
      end else if (m.toggle_enable) begin
        r = cacc_pkg::CM_FREQ;
      end else begin
        r = cacc_pkg::CM_PWM_N;
      end
    end else if (m.toggle_enable) begin
      r = cacc_pkg::CM_HSO;
    end else if (m.rise_capture_enable || m.fall_capture_enable) begin
      r = cacc_pkg::CM_CAPTURE;
    end else if (m.match_flag_enable) begin
      r = cacc_pkg::CM_TIMER;
    end
    return r;
  endfunction : chmode

  // Counter mask for the shared cycle length
  function automatic logic [15:0] len_mask(input logic [1:0] cls);
    logic [15:0] r;
    r = cacc_pkg::MASK_8;
    unique case (cls)
      cacc_pkg::CLS_8:  r = cacc_pkg::MASK_8;
      cacc_pkg::CLS_9:  r = cacc_pkg::MASK_9;
      cacc_pkg::CLS_10: r = cacc_pkg::MASK_10;
      cacc_pkg::CLS_11: r = cacc_pkg::MASK_11;
    endcase
    return r;
  endfunction : len_mask

  // Byte address of a compare register
  function automatic logic [7:0] cmp_addr(input int ch, input logic hi);
    return 8'(int'(cacc_pkg::ADDR_CPL0) + 2 * ch) | {7'h00, hi};
  endfunction : cmp_addr

  // Registers
  cacc_pkg::cacc_mode_reg_t mode_q   [NCH];
  logic [15:0]              cmp_q    [NCH];
  logic [15:0]              reload_q [NCH];
  logic                     view_q;
  logic                     ovie_q;
  logic [1:0]               cls_q;
  logic [2:0]               flag_q;
  logic                     ovf_q;
  logic [2:0]               irq_q;
  logic                     ovirq_q;
  logic [2:0]               pin_q;
  logic [2:0]               oe_q;
  logic [7:0]               rdata_q;
  logic [7:0]               rdata_d;
  logic [2:0]               sync1_q;
  logic [2:0]               sync2_q;
  logic [2:0]               prev_q;

  // Decoded per-channel terms and shared counter terms
  cacc_pkg::cacc_chmode_t md       [NCH];
  logic [2:0]             wr_mode;
  logic [2:0]             wr_lo;
  logic [2:0]             wr_hi;
  logic [2:0]             capture;
  logic [2:0]             match16;
  logic [2:0]             match8;
  logic [2:0]             match_n;
  logic [2:0]             ev_set;
  logic [15:0]            mask;
  logic                   ovf_n;
  logic                   ovf16;

  assign mask  = len_mask(cls_q);
  assign ovf_n = cnt_tick && ((cnt_value & mask) == 16'h0000);
  assign ovf16 = cnt_tick && (cnt_value == 16'h0000);

  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      md[n]      = chmode(mode_q[n]);
      wr_mode[n] = reg_wr && (reg_addr == 8'(int'(cacc_pkg::ADDR_MODE0) + n));
      wr_lo[n]   = reg_wr && (reg_addr == cmp_addr(n, 1'b0));
      wr_hi[n]   = reg_wr && (reg_addr == cmp_addr(n, 1'b1));
      match16[n] = cnt_tick && (cnt_value == cmp_q[n]);
      match8[n]  = cnt_tick && (cnt_value[7:0] == cmp_q[n][7:0]);
      match_n[n] = cnt_tick && (((cnt_value ^ cmp_q[n]) & mask) == 16'h0000);
      capture[n] = (md[n] == cacc_pkg::CM_CAPTURE)
                   && ((mode_q[n].rise_capture_enable && sync2_q[n] && !prev_q[n])
                   ||  (mode_q[n].fall_capture_enable && !sync2_q[n] && prev_q[n]));
      ev_set[n]  = capture[n];
      if (mode_q[n].comparator_enable && mode_q[n].match_flag_enable) begin
        unique case (md[n])
          cacc_pkg::CM_PWM_N:  ev_set[n] = match_n[n];
          cacc_pkg::CM_TIMER,
          cacc_pkg::CM_HSO,
          cacc_pkg::CM_FREQ,
          cacc_pkg::CM_PWM_16: ev_set[n] = match16[n];
          cacc_pkg::CM_IDLE,
          cacc_pkg::CM_CAPTURE: ev_set[n] = capture[n];
        endcase
      end
    end
  end

  // Pin synchroniser and edge history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      prev_q  <= 3'h0;
    end else begin
      sync1_q <= channel_pin_i;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Channel mode registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int n = 0; n < NCH; n++) begin
        mode_q[n] <= cacc_pkg::MODE_RST;
      end
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (wr_mode[n]) begin
          mode_q[n] <= reg_wdata;
        end else if (wr_lo[n] && !view_q) begin
          mode_q[n].comparator_enable <= 1'b0;
        end else if (wr_hi[n] && !view_q) begin
          mode_q[n].comparator_enable <= 1'b1;
        end
      end
    end
  end

  // Pulse configuration register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      view_q <= 1'b0;
      ovie_q <= 1'b0;
      cls_q  <= cacc_pkg::CLS_RST;
    end else if (reg_wr && (reg_addr == cacc_pkg::ADDR_PCFG)) begin
      view_q <= reg_wdata[cacc_pkg::PCFG_VIEW_BIT];
      ovie_q <= reg_wdata[cacc_pkg::PCFG_OVIE_BIT];
      cls_q  <= reg_wdata[cacc_pkg::PCFG_CLS_LSB +: 2];
    end
  end

  // Auto-reload registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int n = 0; n < NCH; n++) begin
        reload_q[n] <= cacc_pkg::CMP_RST;
      end
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (wr_lo[n] && view_q) begin
          reload_q[n][7:0] <= reg_wdata;
        end
        if (wr_hi[n] && view_q) begin
          reload_q[n][15:8] <= reg_wdata;
        end
      end
    end
  end

  // Compare registers: software writes, captures and hardware updates
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int n = 0; n < NCH; n++) begin
        cmp_q[n] <= cacc_pkg::CMP_RST;
      end
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if ((wr_lo[n] || wr_hi[n]) && !view_q) begin
          if (wr_lo[n]) begin
            cmp_q[n][7:0] <= reg_wdata;
          end else begin
            cmp_q[n][15:8] <= reg_wdata;
          end
        end else if (capture[n]) begin
          cmp_q[n] <= cnt_value;
        end else if (md[n] == cacc_pkg::CM_FREQ) begin
          if (mode_q[n].comparator_enable && match8[n]) begin
            cmp_q[n][7:0] <= cmp_q[n][7:0] + cmp_q[n][15:8];
          end
        end else if ((md[n] == cacc_pkg::CM_PWM_N) && ovf_n) begin
          if (cls_q == cacc_pkg::CLS_8) begin
            cmp_q[n][7:0] <= cmp_q[n][15:8];
          end else begin
            cmp_q[n] <= reload_q[n];
          end
        end
      end
    end
  end

  // Channel pin drive
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_q <= 3'h0;
      oe_q  <= 3'h0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        unique case (md[n])
          cacc_pkg::CM_HSO: begin
            oe_q[n] <= 1'b1;
            if (mode_q[n].comparator_enable && match16[n]) begin
              pin_q[n] <= !pin_q[n];
            end
          end
          cacc_pkg::CM_FREQ: begin
            oe_q[n] <= 1'b1;
            if (mode_q[n].comparator_enable && match8[n]) begin
              pin_q[n] <= !pin_q[n];
            end
          end
          cacc_pkg::CM_PWM_N: begin
            oe_q[n] <= 1'b1;
            if (!mode_q[n].comparator_enable) begin
              pin_q[n] <= 1'b0;
            end else if (match_n[n]) begin
              pin_q[n] <= 1'b1;
            end else if (ovf_n) begin
              pin_q[n] <= 1'b0;
            end
          end
          cacc_pkg::CM_PWM_16: begin
            oe_q[n] <= 1'b1;
            if (!mode_q[n].comparator_enable) begin
              pin_q[n] <= 1'b0;
            end else if (match16[n]) begin
              pin_q[n] <= 1'b1;
            end else if (ovf16) begin
              pin_q[n] <= 1'b0;
            end
          end
          cacc_pkg::CM_IDLE,
          cacc_pkg::CM_CAPTURE,
          cacc_pkg::CM_TIMER: begin
            oe_q[n] <= 1'b0;
          end
        endcase
      end
    end
  end

  // Event flags: hardware set wins over a software clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_q <= 3'h0;
      ovf_q  <= 1'b0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (ev_set[n]) begin
          flag_q[n] <= 1'b1;
        end else if (reg_wr && (reg_addr == cacc_pkg::ADDR_FLAGS) && !reg_wdata[n]) begin
          flag_q[n] <= 1'b0;
        end
      end
      if (ovf_n) begin
        ovf_q <= 1'b1;
      end else if (reg_wr && (reg_addr == cacc_pkg::ADDR_FLAGS)
                   && !reg_wdata[cacc_pkg::FLAGS_OVF_BIT]) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // Interrupt request lines
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_q   <= 3'h0;
      ovirq_q <= 1'b0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        irq_q[n] <= flag_q[n] && mode_q[n].channel_irq_enable;
      end
      ovirq_q <= ovf_q && ovie_q;
    end
  end

  // Read data selection
  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr == cacc_pkg::ADDR_PCFG) begin
      rdata_d = {view_q, 1'b0, ovie_q, 3'h0, cls_q};
    end else if (reg_addr == cacc_pkg::ADDR_FLAGS) begin
      rdata_d = {4'h0, ovf_q, flag_q};
    end else if (reg_addr == cacc_pkg::ADDR_PINS) begin
      rdata_d = {5'h00, sync2_q};
    end
    for (int n = 0; n < NCH; n++) begin
      if (reg_addr == 8'(int'(cacc_pkg::ADDR_MODE0) + n)) begin
        rdata_d = mode_q[n];
      end else if (reg_addr == cmp_addr(n, 1'b0)) begin
        rdata_d = view_q ? reload_q[n][7:0] : cmp_q[n][7:0];
      end else if (reg_addr == cmp_addr(n, 1'b1)) begin
        rdata_d = view_q ? reload_q[n][15:8] : cmp_q[n][15:8];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata             = rdata_q;
  assign channel_pin_o         = pin_q;
  assign channel_pin_oe        = oe_q;
  assign channel_event_flag    = flag_q;
  assign channel_irq           = irq_q;
  assign partial_overflow_flag = ovf_q;
  assign partial_overflow_irq  = ovirq_q;

endmodule : cacc_top
